// *** dcrp_pkg.sv ***
package dcrp_pkg;
   // Register byte offsets
   localparam logic [7:0] DCRP_OFF_CTRL    = 8'h00;
   localparam logic [7:0] DCRP_OFF_THR_AS  = 8'h04;
   localparam logic [7:0] DCRP_OFF_THR_NG  = 8'h08;
   localparam logic [7:0] DCRP_OFF_STATUS  = 8'h0C;
   localparam logic [7:0] DCRP_OFF_IRQ_ST  = 8'h10;
   localparam logic [7:0] DCRP_OFF_IRQ_CLR = 8'h14;
   localparam logic [7:0] DCRP_OFF_IRQ_EN  = 8'h18;
   // Control fields
   localparam int DCRP_CTRL_SEP_BIT = 0;  // Separate assert/negate thresholds
   localparam int DCRP_CTRL_RST_BIT = 1;  // Software read-domain reset
   localparam logic [1:0] DCRP_CTRL_RESET = 2'h0;
   // Status fields
   localparam int DCRP_ST_EMPTY = 0;
   localparam int DCRP_ST_AEMPTY = 1;
   localparam int DCRP_ST_PEMPTY = 2;
   localparam int DCRP_ST_VALID = 3;
   localparam int DCRP_ST_INRST = 4;
   localparam int DCRP_ST_CNT_LSB = 8;
   // Interrupt event fields
   localparam int DCRP_EV_UNDERFLOW = 0;
   localparam int DCRP_EV_EMPTY = 1;
   localparam int DCRP_EV_PEMPTY = 2;
   localparam int DCRP_EV_W = 3;
   localparam logic [2:0] DCRP_EV_RESET = 3'h0;
   // Write pointer synchroniser depth
   localparam int DCRP_SYNC_STAGES = 2;
endpackage : dcrp_pkg

// *** dcrp_read_port.sv ***
`timescale 1ns/1ps
// Behaviour
// (R01) All read-side inputs and outputs except the asynchronous presetn and the combinational prdata and pslverr are sampled and updated on pclk only.
// (R02) Read reset clears pointers, flags and output registers on the clock.
// (R03) A read while not empty pops the oldest word onto the data output.
// (R04) Empty flag shows no words; a read while empty moves neither the read pointer nor the data output.
// (R05) Near-empty flag is high when exactly one word is readable.
// (R06) Threshold-empty is high at or below threshold, low above it.
// (R07) Fill count can report one word more than is readable, in the cycle after a read.
// (R08) A read shows in the fill count one clock edge later.
// (R09) A narrower count output keeps the most significant count bits.
// (R10) Valid is high for one cycle after each pop, as the data output takes the popped word.
// (R11) Underflow pulses one cycle after a read refused for empty.
// (R12) Thresholds change only during reset; they are runtime settings.
// (R13) One shared threshold or separate assert and negate thresholds.
// (R14) Separate mode: assert threshold is the low level for asserting.
// (R15) Separate mode: count must exceed negate threshold to clear flag.
// (R16) Gray write pointer passes a multi-stage synchroniser before use.
module dcrp_read_port
   import dcrp_pkg::*;
#(
   parameter int DW   = 32,          // Data width
   parameter int AW   = 4,           // Address width, depth is 2**AW
   parameter int RC_W = AW + 1       // Width of the read count output
) (
   input  wire logic          pclk,         // Read-domain clock
   input  wire logic          presetn,      // Asynchronous reset, active low
   input  wire logic          rd_rst,       // Synchronous read-domain reset
   input  wire logic [7:0]    paddr,        // APB address
   input  wire logic          psel,         // APB select
   input  wire logic          penable,      // APB enable
   input  wire logic          pwrite,       // APB direction
   input  wire logic [31:0]   pwdata,       // APB write data
   output logic      [31:0]   prdata,       // APB read data
   output logic               pready,       // APB ready
   output logic               pslverr,      // APB error on unmapped address
   input  wire logic          rd_en,        // Read request
   input  wire logic [AW:0]   wr_ptr_gray,  // Gray write pointer from writer
   input  wire logic [DW-1:0] mem_rdata,    // Storage read data at mem_raddr
   output logic      [AW-1:0] mem_raddr,    // Storage read address
   output logic      [AW:0]   rd_ptr_gray,  // Gray read pointer to writer
   output logic      [DW-1:0] dout,         // Popped data word
   output logic               valid,        // Dout holds a popped word
   output logic               underflow,    // Previous read was refused
   output logic               empty,        // No word readable
   output logic               almost_empty, // Exactly one word readable
   output logic               prog_empty,   // Count at or below assert threshold; in separate mode held until count exceeds negate threshold
   output logic      [RC_W-1:0] rd_count,   // Fill count, a read shows one edge later
   output logic               irq           // Level interrupt
);

   // Refuse sizes that the pointers, the count field or the synchroniser cannot serve
   if (AW < 1 || DW < 1 || RC_W < 1 || RC_W > AW + 1 ||
       DCRP_ST_CNT_LSB + AW + 1 > 32 || DCRP_SYNC_STAGES < 2) begin : g_chk
      $error("dcrp_read_port: unsupported parameter values");
   end

   logic [AW:0]   wsync_q [DCRP_SYNC_STAGES];
   logic [AW:0]   wbin;
   logic [AW:0]   rptr_q;
   logic [AW:0]   rptr_d;
   logic [AW:0]   avail;
   logic [AW:0]   avail_d;
   logic [AW:0]   count_q;
   logic          empty_q;
   logic          aempty_q;
   logic          pempty_q;
   logic          pempty_d;
   logic          valid_q;
   logic          unf_q;
   logic [DW-1:0] dout_q;
   logic [1:0]    ctrl_q;
   logic [AW:0]   thr_as_q;
   logic [AW:0]   thr_ng_q;
   logic [AW:0]   eff_as_q;
   logic [AW:0]   eff_ng_q;
   logic          eff_sep_q;
   logic [DCRP_EV_W-1:0] ev_st_q;
   logic [DCRP_EV_W-1:0] ev_en_q;
   logic [DCRP_EV_W-1:0] ev_set;
   logic          in_rst;
   logic          pop;
   logic          wr_acc;
   logic          mapped;

   // Gray to binary conversion
   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      // Each binary bit folds in every higher gray bit
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray2bin

   assign in_rst = rd_rst | ctrl_q[DCRP_CTRL_RST_BIT];               // R02
   assign pop    = rd_en & ~empty_q & ~in_rst;                        // R03 R04
   assign wbin   = gray2bin(wsync_q[DCRP_SYNC_STAGES-1]);             // R16
   assign rptr_d = pop ? rptr_q + 1'b1 : rptr_q;
   assign avail   = wbin - rptr_q;                                    // R07
   assign avail_d = wbin - rptr_d;

   // Write pointer synchroniser, last stage alone is read
   // Only gray codes cross, so a pointer caught mid-change is off by one at most
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DCRP_SYNC_STAGES; i++) begin
            wsync_q[i] <= '0;
         end
      end else begin
         wsync_q[0] <= wr_ptr_gray;                                   // R16
         for (int i = 1; i < DCRP_SYNC_STAGES; i++) begin
            wsync_q[i] <= wsync_q[i-1];
         end
      end
   end

   // Read pointer; untouched by a refused read
   always_ff @(posedge pclk or negedge presetn) begin                 // R01
      if (!presetn) begin
         rptr_q <= '0;
      end else if (in_rst) begin
         rptr_q <= '0;                                                // R02
      end else begin
         rptr_q <= rptr_d;                                            // R04
      end
   end

   // Output data; holds until the next pop or read reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= '0;
      end else if (in_rst) begin
         dout_q <= '0;                                                // R02
      end else if (pop) begin
         dout_q <= mem_rdata;                                         // R03
      end
   end

   // Valid and underflow pulses, one cycle per request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= 1'b0;
         unf_q   <= 1'b0;
      end else if (in_rst) begin
         valid_q <= 1'b0;                                             // R02
         unf_q   <= 1'b0;
      end else begin
         valid_q <= pop;                                              // R10
         unf_q   <= rd_en & empty_q;                                  // R11
      end
   end

   // Threshold-empty hysteresis on the next fill level
   // Looking at the next fill keeps the flag in step with empty
   always_comb begin
      pempty_d = pempty_q;
      if (!eff_sep_q) begin
         pempty_d = (avail_d <= eff_as_q);                            // R06 R13
      end else if (avail_d <= eff_as_q) begin
         pempty_d = 1'b1;                                             // R14
      end else if (avail_d > eff_ng_q) begin
         pempty_d = 1'b0;                                             // R15
      end
   end

   // Flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         empty_q  <= 1'b1;
         aempty_q <= 1'b0;
         pempty_q <= 1'b1;
      end else if (in_rst) begin
         empty_q  <= 1'b1;                                            // R02
         aempty_q <= 1'b0;
         pempty_q <= 1'b1;
      end else begin
         empty_q  <= (avail_d == '0);                                 // R04
         aempty_q <= (avail_d == {{AW{1'b0}}, 1'b1});                 // R05
         pempty_q <= pempty_d;
      end
   end

   // Fill count from the pointers before this edge's pop
   // A read therefore shows in the count one edge later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= '0;
      end else if (in_rst) begin
         count_q <= '0;                                               // R02
      end else begin
         count_q <= avail;                                            // R08
      end
   end

   // Thresholds take effect only while the read side is in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_as_q  <= '0;
         eff_ng_q  <= '0;
         eff_sep_q <= 1'b0;
      end else if (in_rst) begin
         eff_as_q  <= thr_as_q;                                       // R12
         eff_ng_q  <= thr_ng_q;
         eff_sep_q <= ctrl_q[DCRP_CTRL_SEP_BIT];                      // R13
      end
   end

   // APB decode
   // Unmapped offsets answer with an error and read as zero
   assign wr_acc = psel & penable & pwrite;
   always_comb begin
      unique case (paddr)
         DCRP_OFF_CTRL, DCRP_OFF_THR_AS, DCRP_OFF_THR_NG, DCRP_OFF_STATUS,
         DCRP_OFF_IRQ_ST, DCRP_OFF_IRQ_CLR, DCRP_OFF_IRQ_EN: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= DCRP_CTRL_RESET;
      end else if (wr_acc && paddr == DCRP_OFF_CTRL) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // Threshold registers; they reach the flag only through a read reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_as_q <= '0;
         thr_ng_q <= '0;
      end else if (wr_acc) begin
         if (paddr == DCRP_OFF_THR_AS) begin
            thr_as_q <= pwdata[AW:0];
         end
         if (paddr == DCRP_OFF_THR_NG) begin
            thr_ng_q <= pwdata[AW:0];
         end
      end
   end

   // Interrupt enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_en_q <= DCRP_EV_RESET;
      end else if (wr_acc && paddr == DCRP_OFF_IRQ_EN) begin
         ev_en_q <= pwdata[DCRP_EV_W-1:0];
      end
   end

   // Sticky events; a new event wins over a clear
   assign ev_set[DCRP_EV_UNDERFLOW] = unf_q;
   assign ev_set[DCRP_EV_EMPTY]     = ~in_rst & ~empty_q & (avail_d == '0);
   assign ev_set[DCRP_EV_PEMPTY]    = ~in_rst & ~pempty_q & pempty_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_st_q <= DCRP_EV_RESET;
      end else if (wr_acc && paddr == DCRP_OFF_IRQ_CLR) begin
         ev_st_q <= (ev_st_q & ~pwdata[DCRP_EV_W-1:0]) | ev_set;
      end else begin
         ev_st_q <= ev_st_q | ev_set;
      end
   end

   // Read data mux
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         DCRP_OFF_CTRL:   prdata[1:0] = ctrl_q;
         DCRP_OFF_THR_AS: prdata[AW:0] = thr_as_q;
         DCRP_OFF_THR_NG: prdata[AW:0] = thr_ng_q;
         DCRP_OFF_STATUS: begin
            prdata[DCRP_ST_EMPTY]  = empty_q;
            prdata[DCRP_ST_AEMPTY] = aempty_q;
            prdata[DCRP_ST_PEMPTY] = pempty_q;
            prdata[DCRP_ST_VALID]  = valid_q;
            prdata[DCRP_ST_INRST]  = in_rst;
            prdata[DCRP_ST_CNT_LSB +: AW+1] = count_q;
         end
         DCRP_OFF_IRQ_ST: prdata[DCRP_EV_W-1:0] = ev_st_q;
         DCRP_OFF_IRQ_EN: prdata[DCRP_EV_W-1:0] = ev_en_q;
         default:         prdata = 32'h0000_0000;
      endcase
   end

   // Port outputs straight from registers or the bus decode
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped;
   assign irq          = |(ev_st_q & ev_en_q);
   assign mem_raddr    = rptr_q[AW-1:0];
   assign rd_ptr_gray  = rptr_q ^ (rptr_q >> 1);
   assign dout         = dout_q;
   assign valid        = valid_q;
   assign underflow    = unf_q;
   assign empty        = empty_q;
   assign almost_empty = aempty_q;
   assign prog_empty   = pempty_q;
   assign rd_count     = count_q[AW -: RC_W];                         // R09

endmodule : dcrp_read_port

// *** dcrp_read_port_props.sv ***
`timescale 1ns/1ps
// Port-level checks of the read side
module dcrp_read_port_props #(
   parameter int DW   = 32,                 // Data width
   parameter int RC_W = 5                   // Count width
) (
   input wire logic            pclk,         // Clock
   input wire logic            presetn,      // Reset, active low
   input wire logic            rd_rst,       // Read reset
   input wire logic            rd_en,        // Read request
   input wire logic            empty,        // Empty flag
   input wire logic            almost_empty, // Near-empty flag
   input wire logic            prog_empty,   // Threshold-empty flag
   input wire logic            valid,        // Popped word shown
   input wire logic            underflow,    // Refused read reported
   input wire logic [DW-1:0]   dout,         // Output data
   input wire logic [DW-1:0]   mem_rdata,    // Storage data
   input wire logic [RC_W-1:0] rd_count      // Fill count
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_POP: assert property (rd_en && !empty && !rd_rst |=> valid && dout == $past(mem_rdata))
      else $error("pop did not present the oldest word");
   AST_VALID_CAUSE: assert property (valid |-> $past(rd_en && !empty && !rd_rst))
      else $error("valid without an accepted read");
   AST_UF_SET: assert property (rd_en && empty && !rd_rst |=> underflow)
      else $error("refused read gave no underflow");
   AST_UF_CAUSE: assert property (underflow |-> $past(rd_en && empty))
      else $error("underflow without a refused read");
   AST_EMPTY_KEEP: assert property (rd_en && empty && !rd_rst |=> !valid && $stable(dout))
      else $error("read while empty changed the output");
   AST_RST: assert property (rd_rst |=> empty && prog_empty && !valid && !underflow)
      else $error("read reset did not clear the flags");
   AST_AE: assert property (almost_empty |-> !empty)
      else $error("near-empty while empty");
   AST_CNT: assert property (empty [*2] |-> rd_count == '0)
      else $error("count above zero while empty");
endmodule : dcrp_read_port_props

bind dcrp_read_port dcrp_read_port_props #(.DW(DW), .RC_W(RC_W)) u_props (
   .pclk(pclk), .presetn(presetn), .rd_rst(rd_rst), .rd_en(rd_en), .empty(empty),
   .almost_empty(almost_empty), .prog_empty(prog_empty), .valid(valid),
   .underflow(underflow), .dout(dout), .mem_rdata(mem_rdata), .rd_count(rd_count));

// *** dcrp_wr_model.sv ***
`timescale 1ns/1ps
// Writer side: storage and a gray write pointer that advances on each request
module dcrp_wr_model #(parameter int DW = 32, parameter int AW = 4) (
   input  wire logic          pclk,        // Clock
   input  wire logic          presetn,     // Reset, active low
   input  wire logic          clr,         // Cleared together with the read side
   input  wire logic          wr_req,      // Store one word
   input  wire logic [DW-1:0] wr_data,     // Word to store
   input  wire logic [AW-1:0] mem_raddr,   // Read address
   output logic      [AW:0]   wr_ptr_gray, // Gray write pointer
   output logic      [DW-1:0] mem_rdata    // Word at the read address
);
   logic [DW-1:0] mem_q [2**AW];
   logic [AW:0]   ptr_q;
   // Store and advance on each request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= '0;
      end else if (clr) begin
         ptr_q <= '0;
      end else if (wr_req) begin
         mem_q[ptr_q[AW-1:0]] <= wr_data;
         ptr_q <= ptr_q + 1'b1;
      end
   end
   assign wr_ptr_gray = ptr_q ^ (ptr_q >> 1);
   assign mem_rdata   = mem_q[mem_raddr];
endmodule : dcrp_wr_model

// *** test_dcrp_read_port.sv ***
`timescale 1ns/1ps
module test_dcrp_read_port;
   import dcrp_pkg::*;
   logic pclk = 0, presetn = 0, rd_rst = 1, psel = 0, penable = 0, pwrite = 0, rd_en = 0;
   logic wr_req = 0, err, pready, pslverr, valid, underflow, empty, almost_empty, prog_empty, irq;
   logic wclr = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, wr_data = 32'h0, prdata, rd, mrd, dout;
   logic [4:0]  wg, rg;
   logic [3:0]  ra;
   logic [2:0]  rd_count;
   logic [31:0] q[$];
   integer seed = 32'h8AAAA772, err_count = 0, check_count = 0, pe = 1, sep = 1, ta = 2, tn = 5;
   integer pc = 0;
   always #50 pclk = ~pclk;
   dcrp_read_port #(.RC_W(3)) uut (.pclk(pclk), .presetn(presetn), .rd_rst(rd_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_en(rd_en), .wr_ptr_gray(wg),
      .mem_rdata(mrd), .mem_raddr(ra), .rd_ptr_gray(rg), .dout(dout), .valid(valid),
      .underflow(underflow), .empty(empty), .almost_empty(almost_empty),
      .prog_empty(prog_empty), .rd_count(rd_count), .irq(irq));
   dcrp_wr_model u_wr (.pclk(pclk), .presetn(presetn), .clr(rd_rst | wclr), .wr_req(wr_req),
      .wr_data(wr_data), .mem_raddr(ra), .wr_ptr_gray(wg), .mem_rdata(mrd));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Expected threshold-empty level from the fill and the level before
   function automatic int exp_pe(input int n, input int prev);
      if (sep != 0) return (n <= ta) ? 1 : ((n > tn) ? 0 : prev);
      return (n <= ta) ? 1 : 0;
   endfunction : exp_pe
   // Gray code of a read pointer that has advanced v times
   function automatic logic [4:0] gray5(input int v);
      logic [4:0] b;
      b = 5'(v);
      return b ^ (b >> 1);
   endfunction : gray5
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Settle, then compare flags and count with the expected fill
   task automatic flags();
      int n;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      n = q.size();
      pe = exp_pe(n, pe);
      chk("empty", empty, n == 0);
      chk("almost_empty", almost_empty, n == 1);
      chk("prog_empty", prog_empty, pe);
      chk("rd_count", rd_count, n >> 2);
      chk("rd_ptr_gray", rg, gray5(pc));
      chk("mem_raddr", ra, pc % 16);
   endtask : flags
   // Thresholds and mode are loaded only while the read side is held in reset
   task automatic cfg(input int s, input int a, input int b);
      @(posedge pclk);
      rd_rst <= 1'b1;
      apb(1, DCRP_OFF_THR_AS, 32'(a), rd);
      apb(1, DCRP_OFF_THR_NG, 32'(b), rd);
      apb(1, DCRP_OFF_CTRL, 32'(s), rd);
      @(posedge pclk);
      rd_rst <= 1'b0;
      sep = s;
      ta = a;
      tn = b;
      pe = 1;
      pc = 0;
      q.delete();
      flags();
   endtask : cfg
   task automatic put(input int n);
      logic [31:0] v;
      repeat (n) begin
         @(posedge pclk);
         v = $random(seed);
         wr_req <= 1'b1;
         wr_data <= v;
         q.push_back(v);
      end
      @(posedge pclk);
      wr_req <= 1'b0;
      flags();
   endtask : put
   task automatic pop();
      @(posedge pclk);
      rd_en <= 1'b1;
      @(posedge pclk);
      rd_en <= 1'b0;
      @(negedge pclk);
      chk("valid", valid, 1);
      chk("dout", dout, q.pop_front());
      pc++;
      flags();
   endtask : pop
   // Read while empty, then look at the interrupt
   task automatic uf(input logic ei);
      @(posedge pclk);
      rd_en <= 1'b1;
      @(posedge pclk);
      rd_en <= 1'b0;
      @(negedge pclk);
      chk("underflow", underflow, 1);
      chk("valid", valid, 0);
      apb(0, DCRP_OFF_IRQ_ST, 32'h0, rd);
      chk("irq_status", rd, 32'h1);
      chk("irq", irq, ei);
   endtask : uf
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      cfg(1, 2, 5);
      put(4);
      put(2);
      repeat (6) pop();
      apb(0, DCRP_OFF_STATUS, 32'h0, rd);
      chk("status", rd, 32'h5);
      $display("test thresholds done");
      apb(1, DCRP_OFF_IRQ_CLR, 32'h7, rd);
      apb(1, DCRP_OFF_IRQ_EN, 32'h1, rd);
      apb(0, DCRP_OFF_IRQ_EN, 32'h0, rd);
      chk("irq_enable", rd, 32'h1);
      uf(1);
      apb(1, DCRP_OFF_IRQ_CLR, 32'h1, rd);
      @(negedge pclk);
      chk("irq", irq, 0);
      apb(1, DCRP_OFF_IRQ_EN, 32'h0, rd);
      uf(0);
      apb(0, 8'h40, 32'h0, rd);
      chk("pslverr", err, 1);
      chk("unmapped", rd, 32'h0);
      $display("test underflow and interrupt done");
      cfg(0, 3, 0);
      put(3);
      put(1);
      @(posedge pclk);
      rd_en <= 1'b1;
      repeat (4) begin
         @(posedge pclk);
         @(negedge pclk);
         chk("valid", valid, 1);
         chk("dout", dout, q.pop_front());
         pc++;
      end
      @(posedge pclk);
      rd_en <= 1'b0;
      @(negedge pclk);
      chk("underflow", underflow, 1);
      flags();
      $display("test back to back done");
      // Soft read reset with the writer cleared alongside
      put(2);
      apb(1, DCRP_OFF_CTRL, 32'h2, rd);
      wclr <= 1'b1;
      apb(0, DCRP_OFF_STATUS, 32'h0, rd);
      chk("status_in_reset", rd, 32'h15);
      chk("pready", pready, 1);
      chk("dout_reset", dout, 32'h0);
      apb(0, DCRP_OFF_THR_AS, 32'h0, rd);
      chk("thr_assert", rd, 32'h3);
      apb(1, DCRP_OFF_CTRL, 32'h0, rd);
      wclr <= 1'b0;
      q.delete();
      pc = 0;
      flags();
      $display("test soft reset done");
      stop_test();
   end
endmodule : test_dcrp_read_port
